// ---- include/sar_ctrl_pkg.sv ----
package sar_ctrl_pkg;
  // Register byte offsets
  localparam logic [11:0] CHANNEL_REF_OFF = 12'h000;
  localparam logic [11:0] CONTROL_OFF     = 12'h004;
  localparam logic [11:0] RESULT_LOW_OFF  = 12'h008;
  localparam logic [11:0] RESULT_HIGH_OFF = 12'h00c;

  // channel_ref_register fields
  localparam int REF_SEL_LSB  = 6;
  localparam int LEFT_ADJ_POS = 5;
  localparam int CHAN_SEL_LSB = 0;

  // converter_control_status fields
  localparam int ENABLE_POS   = 7;
  localparam int START_POS    = 6;
  localparam int FREE_RUN_POS = 5;
  localparam int DONE_POS     = 4;
  localparam int DIV_SEL_LSB  = 0;

  localparam logic [7:0] CHANNEL_REF_RST = 8'h00;
  localparam logic [7:0] CONTROL_RST     = 8'h00;
  localparam logic [9:0] RESULT_RST      = 10'h000;

  localparam int RESULT_BITS = 10;

  // Converter clock cycle counts
  localparam logic [4:0] NORMAL_CYCLES   = 5'd13;
  localparam logic [4:0] FIRST_CYCLES    = 5'd25;
  // Sample-and-hold rises half a cycle after these whole cycles (1.5 and 13.5)
  localparam logic [4:0] NORMAL_SH_CYCLE = 5'd1;
  localparam logic [4:0] FIRST_SH_CYCLE  = 5'd13;

  localparam int SYNC_STAGES = 3;

  typedef enum logic [1:0] {
    CONV_IDLE,
    CONV_SAMPLE,
    CONV_TRIAL,
    CONV_WAIT
  } conv_state_e;
endpackage

// ---- logic/sar_prescaler.sv ----
`timescale 1ns/100ps
`default_nettype none
module sar_prescaler
  import sar_ctrl_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       reset_i,
  input  wire logic       enable_i,
  input  wire logic [2:0] div_sel_i,
  output logic            rise_o,
  output logic            fall_o
);
  logic [6:0] count_q;
  logic [6:0] last_w;
  logic [6:0] half_w;

  // Codes 0 and 1 both divide by two
  assign last_w = (div_sel_i <= 3'h1) ? 7'h01 : 7'((8'h01 << div_sel_i) - 8'h01);
  assign half_w = 7'(last_w >> 1);
  assign rise_o = enable_i && (count_q == last_w);
  assign fall_o = enable_i && (count_q == half_w);

  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
      count_q <= 7'h00;
    else if (!enable_i || count_q >= last_w)
      count_q <= 7'h00;
    else
      count_q <= count_q + 7'h01;
  end
endmodule
`default_nettype wire

// ---- logic/sar_input_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
module sar_input_sync
  import sar_ctrl_pkg::*;
(
  input  wire logic clk_sys_i,
  input  wire logic reset_i,
  input  wire logic async_i,
  output logic      sync_o
);
  logic [SYNC_STAGES-1:0] stage_q;
  logic                   level_q;

  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      stage_q <= '0;
      level_q <= 1'b0;
    end
    else
    begin
      stage_q <= {stage_q[SYNC_STAGES-2:0], async_i};
      // First stage is only read by the second
      if (stage_q[1] == stage_q[2])
        level_q <= stage_q[2];
    end
  end

  assign sync_o = level_q;
endmodule
`default_nettype wire

// ---- logic/sar_adc_control.sv ----
`timescale 1ns/100ps
`default_nettype none
module sar_adc_control
  import sar_ctrl_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        comparator_i,
  input  wire logic        vector_taken_i,
  output logic             analog_enable_o,
  output logic [1:0]       reference_select_o,
  output logic [3:0]       channel_select_o,
  output logic             sample_hold_o,
  output logic [9:0]       trial_code_o,
  output logic             conversion_done_o
);
  // Software-visible registers
  logic [7:0]  chan_ref_q;
  logic        enable_q;
  logic        start_q;
  logic        free_run_q;
  logic        done_q;
  logic [2:0]  div_sel_q;
  logic [9:0]  result_q;
  logic        lock_q;
  logic [31:0] rdata_q;
  logic        err_q;

  // Conversion engine
  conv_state_e state_q;
  logic [4:0]  cycle_q;
  logic        first_q;
  logic [3:0]  bit_q;
  logic [9:0]  code_q;
  logic        sh_q;
  logic [1:0]  ref_buf_q;
  logic [3:0]  chan_buf_q;

  logic adc_rise;
  logic adc_fall;
  logic comp_sync;

  sar_prescaler u_prescaler (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .enable_i  (enable_q),
    .div_sel_i (div_sel_q),
    .rise_o    (adc_rise),
    .fall_o    (adc_fall)
  );

  sar_input_sync u_comp_sync (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .async_i   (comparator_i),
    .sync_o    (comp_sync)
  );

  // Bus decode
  wire setup_w      = psel && !penable;
  wire access_w     = psel && penable;
  wire hit_chan_w   = (paddr == CHANNEL_REF_OFF);
  wire hit_ctrl_w   = (paddr == CONTROL_OFF);
  wire hit_low_w    = (paddr == RESULT_LOW_OFF);
  wire hit_high_w   = (paddr == RESULT_HIGH_OFF);
  wire mapped_w     = hit_chan_w || hit_ctrl_w || hit_low_w || hit_high_w;
  wire wr_w         = access_w && pwrite && mapped_w;
  wire wr_chan_w    = wr_w && hit_chan_w;
  wire wr_ctrl_w    = wr_w && hit_ctrl_w;
  wire rd_low_w     = access_w && !pwrite && hit_low_w;
  wire rd_high_w    = access_w && !pwrite && hit_high_w;

  wire left_adj_w   = chan_ref_q[LEFT_ADJ_POS];
  wire new_enable_w = pwdata[ENABLE_POS];

  // Result and control byte views
  wire [15:0] aligned_w = left_adj_w ? {result_q, 6'h00} : {6'h00, result_q};
  wire [7:0]  ctrl_view_w = {enable_q, start_q, free_run_q, done_q, 1'b0, div_sel_q};

  wire [31:0] rd_mux_w = hit_chan_w ? {24'h000000, chan_ref_q} :
                         hit_ctrl_w ? {24'h000000, ctrl_view_w} :
                         hit_low_w  ? {24'h000000, aligned_w[7:0]} :
                         hit_high_w ? {24'h000000, aligned_w[15:8]} : 32'h00000000;

  assign pready  = access_w;
  assign prdata  = rdata_q;
  assign pslverr = access_w && err_q;

  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      rdata_q <= 32'h00000000;
      err_q   <= 1'b0;
    end
    else if (setup_w)
    begin
      rdata_q <= rd_mux_w;
      err_q   <= !mapped_w;
    end
  end

  // Engine events
  wire [4:0] total_w    = first_q ? FIRST_CYCLES : NORMAL_CYCLES;
  wire [4:0] sh_cycle_w = first_q ? FIRST_SH_CYCLE : NORMAL_SH_CYCLE;
  wire busy_w           = (state_q != CONV_IDLE);
  wire launch_w         = enable_q && start_q && !busy_w && adc_rise;
  wire complete_w       = (state_q == CONV_WAIT) && adc_rise && (cycle_q == total_w - 5'd1);
  wire rerun_w          = complete_w && free_run_q;
  wire sh_fall_w        = (state_q == CONV_SAMPLE) && adc_fall && (cycle_q == sh_cycle_w);
  wire trial_w          = (state_q == CONV_TRIAL) && adc_rise;
  // Buffer follows writes when enabled and idle, except at launch, and in the last cycle before completion
  wire buf_follow_w     = enable_q && (!busy_w || (cycle_q == total_w - 5'd1)) && !launch_w;
  wire [9:0] kept_w     = comp_sync ? code_q : (code_q & ~(10'h001 << bit_q));

  // Control and status register
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      chan_ref_q <= CHANNEL_REF_RST;
      enable_q   <= CONTROL_RST[ENABLE_POS];
      free_run_q <= CONTROL_RST[FREE_RUN_POS];
      div_sel_q  <= CONTROL_RST[DIV_SEL_LSB +: 3];
    end
    else
    begin
      if (wr_chan_w)
        chan_ref_q <= pwdata[7:0];
      if (wr_ctrl_w)
      begin
        enable_q   <= new_enable_w;
        free_run_q <= pwdata[FREE_RUN_POS];
        div_sel_q  <= pwdata[DIV_SEL_LSB +: 3];
      end
    end
  end

  // Start bit: set by software, cleared at single-mode completion
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
      start_q <= CONTROL_RST[START_POS];
    else if (!enable_q)
      start_q <= 1'b0;
    else if (wr_ctrl_w && pwdata[START_POS] && new_enable_w)
      start_q <= 1'b1;
    else if (complete_w && !free_run_q)
      start_q <= 1'b0;
  end

  // Done flag: hardware set wins over software or vector clear
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
      done_q <= CONTROL_RST[DONE_POS];
    else if (complete_w)
      done_q <= 1'b1;
    else if ((wr_ctrl_w && pwdata[DONE_POS]) || vector_taken_i)
      done_q <= 1'b0;
  end

  // Result and read lock
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      result_q <= RESULT_RST;
      lock_q   <= 1'b0;
    end
    else
    begin
      if (complete_w && !lock_q)
        result_q <= code_q;
      if (rd_low_w)
        lock_q <= 1'b1;
      else if (rd_high_w)
        lock_q <= 1'b0;
    end
  end

  // First-conversion marker, armed on each switch-on
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
      first_q <= 1'b1;
    else if (!enable_q)
      first_q <= 1'b1;
    else if (complete_w)
      first_q <= 1'b0;
  end

  // Selection buffer
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      ref_buf_q  <= CHANNEL_REF_RST[REF_SEL_LSB +: 2];
      chan_buf_q <= CHANNEL_REF_RST[CHAN_SEL_LSB +: 4];
    end
    else if (buf_follow_w)
    begin
      ref_buf_q  <= chan_ref_q[REF_SEL_LSB +: 2];
      chan_buf_q <= chan_ref_q[CHAN_SEL_LSB +: 4];
    end
  end

  // Conversion sequencer
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state_q <= CONV_IDLE;
      cycle_q <= 5'd0;
      bit_q   <= 4'd0;
      code_q  <= 10'h000;
      sh_q    <= 1'b0;
    end
    else if (!enable_q)
    begin
      state_q <= CONV_IDLE;
      cycle_q <= 5'd0;
      sh_q    <= 1'b0;
    end
    else
    begin
      case (state_q)
        CONV_IDLE:
        begin
          if (launch_w)
          begin
            state_q <= CONV_SAMPLE;
            cycle_q <= 5'd0;
            sh_q    <= 1'b0;
          end
        end
        CONV_SAMPLE:
        begin
          if (adc_rise)
            cycle_q <= cycle_q + 5'd1;
          if (sh_fall_w)
          begin
            // Hold the input and present the midscale trial
            sh_q    <= 1'b1;
            bit_q   <= 4'(RESULT_BITS - 1);
            code_q  <= 10'h200;
            state_q <= CONV_TRIAL;
          end
        end
        CONV_TRIAL:
        begin
          if (trial_w)
          begin
            cycle_q <= cycle_q + 5'd1;
            if (bit_q == 4'd0)
            begin
              code_q  <= kept_w;
              state_q <= CONV_WAIT;
            end
            else
            begin
              code_q <= kept_w | (10'h001 << (bit_q - 4'd1));
              bit_q  <= bit_q - 4'd1;
            end
          end
        end
        CONV_WAIT:
        begin
          if (complete_w)
          begin
            sh_q    <= 1'b0;
            cycle_q <= 5'd0;
            state_q <= rerun_w ? CONV_SAMPLE : CONV_IDLE;
          end
          else if (adc_rise)
            cycle_q <= cycle_q + 5'd1;
        end
        default:
          state_q <= CONV_IDLE;
      endcase
    end
  end

  // Analog side stays quiet while disabled to save power
  assign analog_enable_o    = enable_q;
  assign reference_select_o = ref_buf_q;
  assign channel_select_o   = chan_buf_q;
  assign sample_hold_o      = sh_q;
  assign trial_code_o       = code_q;
  assign conversion_done_o  = done_q;
endmodule
`default_nettype wire

// ---- bench/sar_adc_control_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none
module sar_adc_control_monitor
  import sar_ctrl_pkg::*;
(
  input wire logic        clk_sys_i,
  input wire logic        reset_i,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        comparator_i,
  input wire logic        vector_taken_i,
  input wire logic        analog_enable_o,
  input wire logic [1:0]  reference_select_o,
  input wire logic [3:0]  channel_select_o,
  input wire logic        sample_hold_o,
  input wire logic [9:0]  trial_code_o,
  input wire logic        conversion_done_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);

  wire acc    = psel && penable;
  wire mapped = paddr inside {CHANNEL_REF_OFF, CONTROL_OFF, RESULT_LOW_OFF, RESULT_HIGH_OFF};

  // Completion cannot land on the next edge while sample-hold is low
  sequence s_clear_req;
    (acc && pwrite && paddr == CONTROL_OFF && pwdata[DONE_POS] || vector_taken_i) && !sample_hold_o;
  endsequence
  sequence s_complete;
    $fell(sample_hold_o) && analog_enable_o;
  endsequence
  sequence s_off_two;
    !analog_enable_o ##1 !analog_enable_o;
  endsequence

  a_bus_ready: assert property (pready == acc)
    else $error("pready not tied to access phase");
  a_unmapped_err: assert property (acc && !mapped |-> pslverr)
    else $error("no error on unmapped address");
  a_read_stable: assert property (acc |=> $stable(prdata))
    else $error("read data changed after access");
  a_sel_held_off: assert property (s_off_two |-> $stable(channel_select_o) && $stable(reference_select_o))
    else $error("selection moved while disabled");
  a_flag_clear: assert property (s_clear_req |=> !conversion_done_o)
    else $error("done flag not cleared");
  a_done_on_complete: assert property (s_complete |-> conversion_done_o)
    else $error("completion without done flag");
  a_off_no_sample: assert property (s_off_two |-> !sample_hold_o)
    else $error("sampling while disabled");
  a_sel_frozen: assert property ($rose(sample_hold_o) |-> analog_enable_o && $stable(channel_select_o))
    else $error("selection moved at sample instant");
endmodule

bind sar_adc_control sar_adc_control_monitor u_mon (.clk_sys_i, .reset_i, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .comparator_i, .vector_taken_i, .analog_enable_o, .reference_select_o,
  .channel_select_o, .sample_hold_o, .trial_code_o, .conversion_done_o);
`default_nettype wire

// ---- bench/test_sar_adc_control.sv ----
`timescale 1ns/100ps
`default_nettype none
module test_sar_adc_control;
  import sar_ctrl_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        comparator_i = 1'b0;
  logic        vector_taken_i = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        analog_enable_o;
  logic [1:0]  reference_select_o;
  logic [3:0]  channel_select_o;
  logic        sample_hold_o;
  logic [9:0]  trial_code_o;
  logic        conversion_done_o;
  logic        last_err;
  int          error_cnt = 0;
  int          cmp_count = 0;
  int          n;
  int          dv;

  sar_adc_control DUT (.clk_sys_i, .reset_i, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .comparator_i, .vector_taken_i, .analog_enable_o, .reference_select_o, .channel_select_o,
    .sample_hold_o, .trial_code_o, .conversion_done_o);

  always #2.5 clk_sys_i = ~clk_sys_i;

  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task apb(input logic [11:0] a, input logic w, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_sys_i);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h0, d};
    @(posedge clk_sys_i);
    penable <= 1'b1;
    do @(posedge clk_sys_i); while (pready !== 1'b1);
    q = prdata[7:0];
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  task wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] q;
    apb(a, 1'b1, d, q);
  endtask

  task rd(input logic [11:0] a, input logic [7:0] e);
    logic [7:0] q;
    apb(a, 1'b0, 8'h00, q);
    check({24'h0, q}, {24'h0, e});
  endtask

  task tick(input int k);
    repeat (k) @(posedge clk_sys_i);
    #1;
  endtask

  // Counts clocks from the edge that took the start write
  task wait_done(output int c);
    c = 1;
    while (conversion_done_o !== 1'b1)
    begin
      @(posedge clk_sys_i);
      #1;
      c++;
    end
  endtask

  task finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    repeat (40000) @(posedge clk_sys_i);
    error_cnt++;
    finish_test();
  end

  initial
  begin
    repeat (10) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    @(posedge clk_sys_i);
    rd(CONTROL_OFF, 8'h00);
    rd(RESULT_LOW_OFF, 8'h00);
    // Low read locks the result; high read must release it before converting
    rd(RESULT_HIGH_OFF, 8'h00);
    rd(12'h010, 8'h00);
    check({31'h0, last_err}, 32'h1);
    $display("test reset done");

    wr(CHANNEL_REF_OFF, 8'hef);
    tick(2);
    check({28'h0, channel_select_o}, 32'h0);
    rd(CHANNEL_REF_OFF, 8'hef);
    wr(CONTROL_OFF, 8'h82);
    tick(2);
    check({26'h0, reference_select_o, channel_select_o}, 32'h3f);
    $display("test select done");

    // Comparator held high keeps every trial bit
    @(posedge clk_sys_i);
    comparator_i <= 1'b1;
    wr(CONTROL_OFF, 8'hc2);
    rd(CONTROL_OFF, 8'hc2);
    wait_done(n);
    check({22'h0, trial_code_o}, 32'h3ff);
    rd(CONTROL_OFF, 8'h92);
    rd(RESULT_LOW_OFF, 8'hc0);
    rd(RESULT_HIGH_OFF, 8'hff);
    wr(CHANNEL_REF_OFF, 8'hcf);
    wr(CONTROL_OFF, 8'hd2);
    wait_done(n);
    rd(RESULT_LOW_OFF, 8'hff);
    comparator_i <= 1'b0;
    wr(CONTROL_OFF, 8'hd2);
    wait_done(n);
    check({31'h0, n >= 13 * 4 && n <= 14 * 4 + 4}, 32'h1);
    check({31'h0, conversion_done_o}, 32'h1);
    rd(RESULT_HIGH_OFF, 8'h03);
    vector_taken_i <= 1'b1;
    @(posedge clk_sys_i);
    vector_taken_i <= 1'b0;
    tick(1);
    check({31'h0, conversion_done_o}, 32'h0);
    wr(CONTROL_OFF, 8'hc2);
    // Mid-conversion: held since 1.5 converter cycles, completion far off
    tick(16);
    check({31'h0, sample_hold_o}, 32'h1);
    wait_done(n);
    rd(RESULT_LOW_OFF, 8'h00);
    rd(RESULT_HIGH_OFF, 8'h00);
    $display("test convert done");

    wr(CONTROL_OFF, 8'hf2);
    wait_done(n);
    wr(CONTROL_OFF, 8'hf2);
    wait_done(n);
    rd(CONTROL_OFF, 8'hf2);
    $display("test free run done");

    // Re-enabling each time forces the long first conversion
    for (int k = 0; k < 8; k++)
    begin
      dv = (k == 0) ? 2 : (1 << k);
      wr(CONTROL_OFF, 8'h00);
      tick(2);
      check({30'h0, analog_enable_o, sample_hold_o}, 32'h0);
      wr(CONTROL_OFF, 8'h90 | 8'(k));
      wr(CONTROL_OFF, 8'hc0 | 8'(k));
      wait_done(n);
      check({31'h0, n >= 25 * dv && n <= 26 * dv + 4}, 32'h1);
    end
    $display("test divide done");
    finish_test();
  end
endmodule
`default_nettype wire
